// ---- design/ssp_consts.svh ----
// constant definitions for the step fifo and spindle sync block
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_AXES          6
`define SSP_FIFO_DEPTH    20
`define SSP_PTR_W         5
`define SSP_CNT_W         32
`define SSP_DB_W          16
`define SSP_CLK_NS        20
`define SSP_MIN_PULSE_NS  60
`define SSP_MIN_PULSE_CYC ((`SSP_MIN_PULSE_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_SPD_MIN_HALF  32'h0000_0002
`define SSP_CNT_ONE       32'h0000_0001
`define SSP_CNT_ZERO      32'h0000_0000
`define SSP_PTR_ONE       5'h01
`define SSP_PTR_ZERO      5'h00
`define SSP_PTR_LAST      5'h13
`endif

// ---- design/ssp_debounce.sv ----
// synchroniser and lockout debouncer for one spindle sensor input
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_debounce (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 pin_in,     // raw sensor pin
    input  wire logic [`SSP_DB_W-1:0] lock_cyc,   // lockout length after a change
    output logic                      level_r,    // debounced level
    output logic                      rise_r      // one-cycle pulse on a clean rising edge
);
    logic                 sync1_r;     // first synchroniser stage, read only by sync2_r
    logic                 sync2_r;     // second synchroniser stage
    logic [`SSP_DB_W-1:0] lock_r;      // remaining lockout cycles

    // two flops against metastability
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // accept a change only outside the lockout; either polarity restarts it
    // a pulse of one cycle (20 ns) or longer is seen when it starts outside the lockout, no upper bound
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            level_r <= 1'b0;
            rise_r  <= 1'b0;
            lock_r  <= '0;
        end else begin
            rise_r <= 1'b0;
            if (lock_r != '0) begin
                lock_r <= lock_r - 1'b1;
            end else if (sync2_r != level_r) begin
                level_r <= sync2_r;
                rise_r  <= sync2_r;
                lock_r  <= lock_cyc;
            end
        end
    end

    lockout_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        (level_r != $past(level_r)) && (lock_cyc > 16'h0001) |=> $stable(level_r))
        else $error("debounced level changed inside lockout");
endmodule : ssp_debounce

// ---- design/ssp_pkg.sv ----
// types shared by the step fifo and spindle sync block
package ssp_pkg;
    // one elementary step word: step and direction per axis
    typedef struct packed {
        logic [5:0] dir;
        logic [5:0] step;
    } ssp_step_s;

    // spindle generator command
    typedef struct packed {
        logic        run;
        logic        dir;
        logic [31:0] half_period;
    } ssp_spin_s;

    // output sequencer state
    typedef enum logic [1:0] {
        SSP_IDLE  = 2'b00,
        SSP_ARMED = 2'b01,
        SSP_RUN   = 2'b10
    } ssp_seq_e;
endpackage : ssp_pkg

// ---- design/ssp_spindle_gen.sv ----
// free-running 50 percent duty spindle step generator
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_spindle_gen (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire ssp_pkg::ssp_spin_s cmd,     // held command, one write changes it
    output logic                  step_r,    // spindle step square wave
    output logic                  dir_r      // spindle direction
);
    logic [`SSP_CNT_W-1:0] half_r;   // cycles into current half period
    logic [`SSP_CNT_W-1:0] lim;      // clamped half period

    // clamp keeps the rate at or below a quarter of the clock
    always_comb begin
        lim = (cmd.half_period < `SSP_SPD_MIN_HALF) ? `SSP_SPD_MIN_HALF : cmd.half_period;
    end

    // equal high and low halves; no ramping here, software ramps by rewriting
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            step_r <= 1'b0;
            dir_r  <= 1'b0;
            half_r <= '0;
        end else if (!cmd.run) begin
            step_r <= 1'b0;
            half_r <= '0;
            dir_r  <= cmd.dir;
        end else if (half_r >= lim - `SSP_CNT_ONE) begin
            step_r <= ~step_r;
            half_r <= '0;
        end else begin
            half_r <= half_r + `SSP_CNT_ONE;
        end
    end

    step_quarter_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(step_r) && cmd.run |=> step_r)
        else $error("spindle step high for less than two cycles");
    stop_low_a: assert property (@(posedge core_clk) disable iff (reset)
        !cmd.run |=> !step_r)
        else $error("spindle step running while stopped");
endmodule : ssp_spindle_gen

// ---- design/ssp_step_sync.sv ----
// step fifo with thread start gating and spindle period measurement
// Operation
// - fifo holds twenty six-axis step words
// - pop one word per step interval, autonomously
// - spindle square wave, half duty, steady
// - one write starts, stops, or retunes spindle
// - spindle rate at most clock over four
// - sensor pulses over sixty ns are registered
// - per-input debouncer with configurable lockout
// - threading holds output until index pulse
// - index to output start jitter up to one step interval
// - sensor pulse latches and restarts period counter
// - interrupt on every latched period
// - timing sensor clocks measurement if installed
// - step interval is clock over base divisor
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_step_sync (
    input  wire logic                   core_clk,
    input  wire logic                   reset,
    input  wire logic                   wr_en,          // host write strobe for a step word
    input  wire ssp_pkg::ssp_step_s     wr_data,        // step word from host
    input  wire logic [`SSP_CNT_W-1:0]  base_div,       // base divisor, cycles per step interval
    input  wire logic                   thread_mode,    // hold output until index
    input  wire logic                   timing_fitted,  // multi-pulse sensor installed
    input  wire logic [`SSP_DB_W-1:0]   index_lock,     // index debounce lockout cycles
    input  wire logic [`SSP_DB_W-1:0]   timing_lock,    // timing debounce lockout cycles
    input  wire ssp_pkg::ssp_spin_s     spin_cmd,       // spindle command word
    input  wire logic                   index_pin,      // once-per-rev sensor pin
    input  wire logic                   timing_pin,     // multi-pulse sensor pin
    output ssp_pkg::ssp_step_s          axis_out_r,     // axis step and dir outputs
    output logic                        spin_step_r,    // spindle step
    output logic                        spin_dir_r,     // spindle dir
    output logic                        fifo_full_r,    // no room for another word
    output logic [`SSP_PTR_W-1:0]       fifo_level_r,   // words queued
    output logic [`SSP_CNT_W-1:0]       period_r,       // last spindle period in clocks
    output logic                        period_irq_r,   // one-cycle pulse on new period
    output logic                        running_r       // fifo output enabled
);
    ssp_pkg::ssp_step_s    mem [0:`SSP_FIFO_DEPTH-1];   // step word storage
    logic [`SSP_PTR_W-1:0] rd_ptr_r;                    // read index
    logic [`SSP_PTR_W-1:0] wr_ptr_r;                    // write index
    logic [`SSP_CNT_W-1:0] div_cnt_r;                   // step interval divider
    logic [`SSP_CNT_W-1:0] per_cnt_r;                   // running period counter
    logic                  tick;                        // step interval enable
    logic                  push;                        // accepted write
    logic                  pop;                         // word taken this interval
    logic                  index_rise;                  // clean index edge
    logic                  timing_rise;                 // clean timing edge
    logic                  meas_pulse;                  // selected measurement edge
    ssp_pkg::ssp_seq_e     seq_r;                       // output sequencer
    logic                  spin_step_w;                 // spindle step from generator
    logic                  spin_dir_w;                  // spindle dir from generator

    // wrap a fifo index around the twenty slots
    function automatic logic [`SSP_PTR_W-1:0] ptr_inc(input logic [`SSP_PTR_W-1:0] p);
        ptr_inc = (p == `SSP_PTR_LAST) ? `SSP_PTR_ZERO : p + `SSP_PTR_ONE;
    endfunction : ptr_inc

    // writes into a full fifo are dropped; host is expected to wait for room
    assign push = wr_en && !fifo_full_r;
    assign pop  = tick && (seq_r == ssp_pkg::SSP_RUN) && (fifo_level_r != `SSP_PTR_ZERO);
    assign meas_pulse = timing_fitted ? timing_rise : index_rise;
    assign tick = (div_cnt_r == `SSP_CNT_ZERO);

    // step interval divider: one tick every base_div clocks
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_cnt_r <= '0;
        end else if (tick) begin
            // zero or one divisor degrades to a tick every clock
            div_cnt_r <= (base_div > `SSP_CNT_ONE) ? base_div - `SSP_CNT_ONE : `SSP_CNT_ZERO;
        end else begin
            div_cnt_r <= div_cnt_r - `SSP_CNT_ONE;
        end
    end

    // storage array, written by the host side only
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= wr_data;
        end
    end

    // pointers and occupancy; simultaneous push and pop keep the level
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_r     <= '0;
            rd_ptr_r     <= '0;
            fifo_level_r <= '0;
            fifo_full_r  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            case ({push, pop})
                2'b10: begin
                    fifo_level_r <= fifo_level_r + `SSP_PTR_ONE;
                    fifo_full_r  <= (fifo_level_r == `SSP_PTR_LAST);
                end
                2'b01: begin
                    fifo_level_r <= fifo_level_r - `SSP_PTR_ONE;
                    fifo_full_r  <= 1'b0;
                end
                default: begin
                    fifo_level_r <= fifo_level_r;
                end
            endcase
        end
    end

    // sequencer: threading arms and waits for the index edge
    // the edge passes the synchroniser and debouncer first, and the first word waits for the next tick
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            seq_r <= ssp_pkg::SSP_IDLE;
        end else begin
            case (seq_r)
                ssp_pkg::SSP_IDLE: begin
                    seq_r <= thread_mode ? ssp_pkg::SSP_ARMED : ssp_pkg::SSP_RUN;
                end
                ssp_pkg::SSP_ARMED: begin
                    if (!thread_mode) begin
                        seq_r <= ssp_pkg::SSP_RUN;
                    end else if (index_rise) begin
                        seq_r <= ssp_pkg::SSP_RUN;
                    end
                end
                ssp_pkg::SSP_RUN: begin
                    // output stays enabled; only a reset re-arms for another pass
                    seq_r <= ssp_pkg::SSP_RUN;
                end
                default: begin
                    seq_r <= ssp_pkg::SSP_IDLE;
                end
            endcase
        end
    end

    // running flag follows the sequencer a cycle later; only a reset rearms it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            running_r <= 1'b0;
        end else begin
            running_r <= (seq_r == ssp_pkg::SSP_RUN);
        end
    end

    // axis outputs: one word per interval, nothing when empty or held
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            axis_out_r <= '0;
        end else if (pop) begin
            axis_out_r <= mem[rd_ptr_r];
        end else if (tick) begin
            axis_out_r.step <= '0;
        end
    end

    // period counter: latch old count and restart on each measurement edge
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            per_cnt_r    <= '0;
            period_r     <= '0;
            period_irq_r <= 1'b0;
        end else begin
            period_irq_r <= meas_pulse;
            if (meas_pulse) begin
                period_r  <= per_cnt_r;
                per_cnt_r <= `SSP_CNT_ONE;
            end else begin
                per_cnt_r <= per_cnt_r + `SSP_CNT_ONE;
            end
        end
    end

    // spindle outputs registered once more so top outputs come from flops
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            spin_step_r <= 1'b0;
            spin_dir_r  <= 1'b0;
        end else begin
            spin_step_r <= spin_step_w;
            spin_dir_r  <= spin_dir_w;
        end
    end

    ssp_debounce u_index_db (
        .core_clk (core_clk),
        .reset    (reset),
        .pin_in   (index_pin),
        .lock_cyc (index_lock),
        .level_r  (),
        .rise_r   (index_rise)
    );

    ssp_debounce u_timing_db (
        .core_clk (core_clk),
        .reset    (reset),
        .pin_in   (timing_pin),
        .lock_cyc (timing_lock),
        .level_r  (),
        .rise_r   (timing_rise)
    );

    ssp_spindle_gen u_spin (
        .core_clk (core_clk),
        .reset    (reset),
        .cmd      (spin_cmd),
        .step_r   (spin_step_w),
        .dir_r    (spin_dir_w)
    );

    // a full fifo never grows
    full_no_grow_a: assert property (@(posedge core_clk) disable iff (reset)
        fifo_full_r && !pop |=> fifo_level_r == $past(fifo_level_r))
        else $error("fifo level grew while full");
    level_max_a: assert property (@(posedge core_clk) disable iff (reset)
        fifo_level_r <= `SSP_PTR_LAST + `SSP_PTR_ONE)
        else $error("fifo level above twenty");
    one_per_tick_a: assert property (@(posedge core_clk) disable iff (reset)
        pop |-> tick)
        else $error("word popped outside step interval");
    empty_no_step_a: assert property (@(posedge core_clk) disable iff (reset)
        tick && fifo_level_r == `SSP_PTR_ZERO |=> axis_out_r.step == '0)
        else $error("step pulses while fifo empty");
    armed_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        seq_r == ssp_pkg::SSP_ARMED |-> !pop)
        else $error("fifo output while armed for threading");
    index_start_a: assert property (@(posedge core_clk) disable iff (reset)
        seq_r == ssp_pkg::SSP_ARMED && thread_mode && index_rise |=> seq_r == ssp_pkg::SSP_RUN)
        else $error("threading did not start on index edge");
    period_latch_a: assert property (@(posedge core_clk) disable iff (reset)
        meas_pulse |=> period_r == $past(per_cnt_r) && per_cnt_r == `SSP_CNT_ONE)
        else $error("period not latched on measurement edge");
    irq_follow_a: assert property (@(posedge core_clk) disable iff (reset)
        $changed(period_r) |-> period_irq_r)
        else $error("period latched without interrupt");
    source_sel_a: assert property (@(posedge core_clk) disable iff (reset)
        timing_fitted && index_rise && !timing_rise |=> !period_irq_r)
        else $error("index clocked measurement with timing fitted");
    divider_a: assert property (@(posedge core_clk) disable iff (reset)
        tick && base_div > `SSP_CNT_ONE |=> !tick)
        else $error("step interval shorter than divisor");
endmodule : ssp_step_sync

// ---- dv/ssp_host_model.sv ----
// host side model: step word writer, divisor rescaler and spindle commander
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_host_model (
    input  wire logic                  core_clk,
    input  wire logic                  fifo_full_r,   // device has no room
    input  wire logic                  period_irq_r,  // new spindle period ready
    input  wire logic [`SSP_CNT_W-1:0] period_r,      // latched spindle period
    output logic                       wr_en,         // step word write strobe
    output ssp_pkg::ssp_step_s         wr_data,       // step word
    output logic [`SSP_CNT_W-1:0]      base_div,      // kernel divisor
    output ssp_pkg::ssp_spin_s         spin_cmd       // spindle command
);
    logic [`SSP_CNT_W-1:0] ref_period = 32'h0000_00c8;  // period used when planning the pass
    logic                  rescale_on = 1'b0;           // rescaling off until the bench turns it on after threading

    // quiet bus at time zero
    initial begin
        wr_en = 1'b0;
        wr_data = '0;
        base_div = 32'h0000_0006;
        spin_cmd = '0;
    end

    // one word; waits for room unless told to write into a full fifo anyway
    task automatic push(input ssp_pkg::ssp_step_s w, input logic force_wr);
        int n;
        n = 0;
        while (fifo_full_r === 1'b1 && !force_wr && n < 5000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        wr_en = 1'b1;
        wr_data = w;
        @(posedge core_clk);
        #1;
        wr_en = 1'b0;
    endtask : push

    // speed ramp done by successive single writes, the generator never ramps
    task automatic ramp(input logic [31:0] from_hp, input logic [31:0] to_hp);
        for (logic [31:0] hp = from_hp; hp >= to_hp; hp--) begin
            @(posedge core_clk);
            #1;
            spin_cmd = '{run: 1'b1, dir: 1'b1, half_period: hp};
        end
    endtask : ramp

    // divisor follows the measured period so feed per turn stays fixed
    always @(posedge core_clk) begin
        if (rescale_on && period_irq_r === 1'b1 && period_r != 32'h0) begin
            #1;
            base_div = (base_div * period_r) / ref_period;
        end
    end
endmodule : ssp_host_model

// ---- dv/tb.sv ----
// self-checking bench for the step fifo and spindle sync block
`timescale 1ns/1ps
`include "ssp_consts.svh"
module tb;
    logic core_clk = 1'b0, reset = 1'b1, thread_mode = 1'b0, timing_fitted = 1'b0;
    logic index_pin = 1'b0, timing_pin = 1'b0;
    logic [15:0] index_lock = 16'h0004, timing_lock = 16'h0004;  // lockout lengths
    logic wr_en, spin_step_r, spin_dir_r, fifo_full_r, period_irq_r, running_r;
    logic [31:0] base_div, period_r, p1;
    logic [4:0] fifo_level_r, lv;
    ssp_pkg::ssp_step_s wr_data, axis_out_r;
    ssp_pkg::ssp_spin_s spin_cmd;
    ssp_pkg::ssp_step_s row_in[20];   // words handed to the fifo
    logic [11:0]        row_exp[20];  // words expected at the axis outputs
    int checks = 0, fail_count = 0, lat_a, lat_b, k, n;

    always #10 core_clk = ~core_clk;

    ssp_step_sync i_ssp_step_sync (.core_clk(core_clk), .reset(reset), .wr_en(wr_en), .wr_data(wr_data),
        .base_div(base_div), .thread_mode(thread_mode), .timing_fitted(timing_fitted),
        .index_lock(index_lock), .timing_lock(timing_lock), .spin_cmd(spin_cmd), .index_pin(index_pin),
        .timing_pin(timing_pin), .axis_out_r(axis_out_r), .spin_step_r(spin_step_r), .spin_dir_r(spin_dir_r),
        .fifo_full_r(fifo_full_r), .fifo_level_r(fifo_level_r), .period_r(period_r),
        .period_irq_r(period_irq_r), .running_r(running_r));
    ssp_host_model i_host (.core_clk(core_clk), .fifo_full_r(fifo_full_r), .period_irq_r(period_irq_r),
        .period_r(period_r), .wr_en(wr_en), .wr_data(wr_data), .base_div(base_div), .spin_cmd(spin_cmd));

    // one compare, counted; mismatches reported at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic end_of_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    // queue n rows, fire the index and follow every word out; returns index to start latency
    task automatic thread_pass(input int n_w, input int skew, output int lat);
        thread_mode = 1'b1;
        for (int i = 0; i < n_w; i++) i_host.push(row_in[i], 1'b0); // rows go in one at a time, each waiting for room
        if (n_w == 20) begin
            chk(fifo_full_r, 32'h1);
            i_host.push(row_in[0], 1'b1);
            chk(fifo_level_r, 32'h14);
        end
        repeat (10 + skew) @(posedge core_clk);
        #1;
        chk({running_r, fifo_level_r}, {1'b0, 5'(n_w)});
        lv = 5'(n_w);
        index_pin = 1'b1;
        for (lat = 1; lat < 40 && running_r !== 1'b1; lat++) begin
            @(posedge core_clk);
            #1;
            if (lat == 3) index_pin = 1'b0;
        end
        for (int i = 0; i < n_w; i++) begin
            for (k = 0; fifo_level_r === lv && k < 100; k++) begin
                @(posedge core_clk);
                #1;
            end
            lv = fifo_level_r;
            chk(axis_out_r, row_exp[i]);
            if (i > 0) chk(k, base_div);
        end
        repeat (8) @(posedge core_clk);
        #1;
        chk(axis_out_r.step, 32'h0);
    endtask : thread_pass

    // one 60 ns pulse on a sensor pin; k is the cycle of the period interrupt, 21 if none
    task automatic sense(input logic on_timing);
        @(posedge core_clk);
        #1;
        if (on_timing) timing_pin = 1'b1;
        else index_pin = 1'b1;
        for (k = 1; k < 21; k++) begin
            @(posedge core_clk);
            #1;
            if (k == 3) {timing_pin, index_pin} = 2'b00;
            if (period_irq_r === 1'b1) break;
        end
    endtask : sense

    // high and low time of the spindle wave, in cycles
    task automatic spin_half(input int exp);
        int hi, lo, w;
        hi = 0;
        lo = 0;
        for (w = 0; spin_step_r !== 1'b0 && w < 200; w++) @(posedge core_clk);
        for (w = 0; spin_step_r !== 1'b1 && w < 200; w++) @(posedge core_clk);
        for (; spin_step_r === 1'b1 && hi < 200; hi++) @(posedge core_clk);
        for (; spin_step_r === 1'b0 && lo < 200; lo++) @(posedge core_clk);
        chk(hi, exp);
        chk(lo, exp);
    endtask : spin_half

    // watchdog well past the expected run of about 1000 cycles
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end

    // main sequence
    initial begin
        for (int i = 0; i < 20; i++) begin
            row_in[i] = '{dir: 6'(i), step: 6'(i + 1)};
            row_exp[i] = {6'(i), 6'(i + 1)};
        end
        repeat (16) @(posedge core_clk);
        #1;
        chk({axis_out_r, spin_step_r, fifo_full_r, fifo_level_r, period_irq_r, running_r}, 32'h0);
        chk(period_r, 32'h0);
        reset = 1'b0;
        $display("done: reset");
        thread_pass(20, 0, lat_a);
        reset = 1'b1;
        @(posedge core_clk);
        #1;
        reset = 1'b0;
        thread_pass(5, 1, lat_b);
        chk(lat_b, lat_a);
        thread_mode = 1'b0;
        $display("done: fifo and threading");
        i_host.spin_cmd = '{run: 1'b1, dir: 1'b0, half_period: 32'h5};
        spin_half(5);
        i_host.spin_cmd.half_period = 32'h1;
        spin_half(2);
        i_host.ramp(32'ha, 32'h3);
        spin_half(3);
        #1;
        i_host.spin_cmd.run = 1'b0;
        repeat (10) @(posedge core_clk);
        chk(spin_dir_r, 32'h1);
        n = 0;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            n += int'(spin_step_r === 1'b1);
        end
        chk(n, 0);
        $display("done: spindle");
        i_host.rescale_on = 1'b1;
        sense(1'b0);
        chk(k, 4);
        repeat (195) @(posedge core_clk);
        sense(1'b0);
        p1 = period_r;
        repeat (295) @(posedge core_clk);
        sense(1'b0);
        chk(period_r - p1, 32'h64);
        timing_fitted = 1'b1;
        timing_lock = 16'h000a;
        sense(1'b0);
        chk(k, 21);
        sense(1'b1);
        chk(k, 4);
        repeat (30) @(posedge core_clk);
        n = 0;
        for (k = 0; k < 30; k++) begin
            timing_pin = (k < 8) ? 8'b1110_0111 >> k : 1'b0;
            @(posedge core_clk);
            #1;
            n += int'(period_irq_r === 1'b1);
        end
        chk(n, 1);
        $display("done: sensors");
        end_of_test();
    end
endmodule : tb
